/* src/sbc_diag_pkg.sv */
// Package: frame layout, mode and select codes, diagnostic encodings for the SPI readout
package sbc_diag_pkg;

	// ---------------------------------------------------------------
	// Frame layout (shifted least significant bit first)
	// ---------------------------------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int MS_W       = 3;
	localparam int CS_W       = 3;
	localparam int DATA_W     = 10;
	localparam int CNT_W      = 5;
	localparam int REG_COUNT  = 8;

	localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;  // Frame complete, extra clocks ignored
	localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;  // Last data bit of a frame
	localparam logic [CNT_W-1:0] CNT_DATA = 5'h06;  // First bit after mode and select

	// ---------------------------------------------------------------
	// Mode selection codes (encoding chosen for this block)
	// ---------------------------------------------------------------
	localparam logic [MS_W-1:0] MS_NORMAL    = 3'h0;
	localparam logic [MS_W-1:0] MS_SLEEP     = 3'h1;
	localparam logic [MS_W-1:0] MS_RESTART   = 3'h2;
	localparam logic [MS_W-1:0] MS_FAILSAFE  = 3'h3;
	localparam logic [MS_W-1:0] MS_INIT      = 3'h4;
	localparam logic [MS_W-1:0] MS_FLASH     = 3'h5;
	localparam logic [MS_W-1:0] MS_READ_ONLY = 3'h6;

	// ---------------------------------------------------------------
	// Configuration select codes
	// ---------------------------------------------------------------
	localparam logic [CS_W-1:0] CS_WAKE   = 3'h0;
	localparam logic [CS_W-1:0] CS_CONFIG = 3'h4;
	localparam logic [CS_W-1:0] CS_DIAG   = 3'h7;

	// ---------------------------------------------------------------
	// Configuration register layout and reset value
	// ---------------------------------------------------------------
	localparam logic [DATA_W-1:0] CFG_DEFAULT  = 10'h115;
	localparam int                CFG_LH_BIT   = 6;
	localparam int                CFG_WDLH_BIT = 8;

	// ---------------------------------------------------------------
	// Restart cause and fallback cause encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] RC_NONE      = 2'h0;
	localparam logic [1:0] RC_UNDERVOLT = 2'h1;
	localparam logic [1:0] RC_WATCHDOG  = 2'h2;
	localparam logic [1:0] RC_COMMAND   = 2'h3;

	localparam logic [2:0] FB_NONE        = 3'h0;
	localparam logic [2:0] FB_UV_TIMEOUT  = 3'h1;
	localparam logic [2:0] FB_WD_ONE      = 3'h2;
	localparam logic [2:0] FB_WD_TWO      = 3'h3;
	localparam logic [2:0] FB_INIT_TMO    = 3'h4;
	localparam logic [2:0] FB_THERMAL     = 3'h5;
	localparam logic [2:0] FB_RESET_CLAMP = 3'h6;

	localparam int STRAP_DEV_BIT = 2;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef logic [DATA_W-1:0] reg_word_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [CS_W-1:0]   cs;
		logic [MS_W-1:0]   ms;
	} spi_frame_s;

	typedef struct packed {
		logic [1:0] restart_cause;   // restart_cause_hi, restart_cause_lo
		logic [2:0] fallback_cause;  // fallback_cause_b2..b0
		logic [2:0] strap_readout;   // strap_readout_b2..b0
	} diag_s;

endpackage

/* src/sbc_spi_diagnostic_readout.sv */
// SPI slave diagnostic readout: restart/fallback causes, strap readout, frame responses
`timescale 1ns/1ns
`default_nettype none

module sbc_spi_diagnostic_readout
	import sbc_diag_pkg::*;
(
	// System clock and reset
	input  wire logic                            clk_sys_i,
	input  wire logic                            reset_i,
	// SPI link, clock idles high
	input  wire logic                            spi_clk_i,
	input  wire logic                            spi_csn_i,
	input  wire logic                            spi_sdi_i,
	output logic                                 spi_sdo_o,
	output logic                                 spi_sdo_oe_n_o,
	// Mode context from the device state machine
	input  wire logic [MS_W-1:0]                 cur_mode_i,
	input  wire logic                            normal_entry_i,
	input  wire logic [MS_W-1:0]                 prev_mode_i,
	input  wire logic                            restart_by_uc_i,
	input  wire logic                            return_clear_i,
	// Failure events
	input  wire logic                            uv_restart_i,
	input  wire logic                            wd_fail_i,
	input  wire logic                            wd_ok_i,
	input  wire logic                            cyclic_nack_i,
	input  wire logic                            flash_cmd_i,
	input  wire logic                            ext_reset_i,
	input  wire logic                            fb_event_i,
	input  wire logic [2:0]                      fb_code_i,
	// Pins
	input  wire logic                            strap_int_i,
	input  wire logic                            test_pin_i,
	// Other registers of the device, shown on readout
	input  wire logic [REG_COUNT-1:0][DATA_W-1:0] ext_bank_i,
	// Command outputs
	output logic                                 wd_trigger_o,
	output logic                                 mode_req_o,
	output logic [MS_W-1:0]                      mode_code_o,
	output logic                                 wr_strobe_o,
	output spi_frame_s                           wr_frame_o,
	output logic                                 int_clear_o,
	output logic [CS_W-1:0]                      int_sel_o,
	// Status outputs
	output logic                                 fallback_on_o,
	output logic                                 wd_fallback_count_o,
	output logic                                 sw_dev_mode_o,
	output diag_s                                diag_o
);

	// ---------------------------------------------------------------
	// Link domain: receive
	// ---------------------------------------------------------------
	logic [CNT_W-1:0]      bit_cnt_ff;
	logic                  rx_valid_ff;
	logic [FRAME_BITS-1:0] rx_sh_ff;
	spi_frame_s            rx_frame;
	logic                  sdo_ff;
	logic                  sdo_oe_n_ff;
	logic                  tx_bit;
	logic [3:0]            data_idx;

	// Snapshots written by the system side while the link is idle
	reg_word_t             bank_snap_ff [REG_COUNT];
	logic [FRAME_BITS-1:0] tx_snap_ff;

	assign rx_frame = rx_sh_ff;

	// Bit counter; chip select high ends the frame with no clock needed
	always_ff @(posedge spi_clk_i or posedge spi_csn_i) begin
		if (spi_csn_i) begin
			bit_cnt_ff  <= '0;
			rx_valid_ff <= 1'b0;
		end else if (bit_cnt_ff != CNT_FULL) begin
			bit_cnt_ff <= bit_cnt_ff + 5'h1;
			if (bit_cnt_ff == CNT_LAST) begin
				rx_valid_ff <= 1'b1;  // Only full frames count as commands
			end
		end
	end

	// Incoming bit k lands at position k
	always_ff @(posedge spi_clk_i) begin
		if (bit_cnt_ff != CNT_FULL) begin
			rx_sh_ff[bit_cnt_ff[3:0]] <= spi_sdi_i;
		end
	end

	// ---------------------------------------------------------------
	// Link domain: transmit
	// ---------------------------------------------------------------
	// Bit to drive on the coming falling edge
	always_comb begin
		data_idx = 4'(bit_cnt_ff - CNT_DATA);
		tx_bit   = 1'b0;
		if (bit_cnt_ff != CNT_FULL) begin
			if (rx_frame.ms == MS_READ_ONLY && bit_cnt_ff >= CNT_DATA) begin
				tx_bit = bank_snap_ff[rx_frame.cs][data_idx];
			end else begin
				tx_bit = tx_snap_ff[bit_cnt_ff[3:0]];
			end
		end
	end

	// First falling edge puts bit 0 out; release the pin when deselected
	always_ff @(negedge spi_clk_i or posedge spi_csn_i) begin
		if (spi_csn_i) begin
			sdo_ff      <= 1'b0;
			sdo_oe_n_ff <= 1'b1;
		end else begin
			sdo_ff      <= tx_bit;
			sdo_oe_n_ff <= 1'b0;
		end
	end

	assign spi_sdo_o      = sdo_ff;
	assign spi_sdo_oe_n_o = sdo_oe_n_ff;

	// ---------------------------------------------------------------
	// System domain: synchronisers
	// ---------------------------------------------------------------
	logic csn_s1_ff, csn_s2_ff;
	logic vld_s1_ff, vld_s2_ff, vld_s3_ff;
	logic test_s1_ff, test_s2_ff;
	logic strap_s1_ff, strap_s2_ff;
	logic frame_acc;
	logic is_ro;

	// Two flops per foreign signal; the third valid flop only feeds the edge
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			csn_s1_ff <= 1'b1;
			csn_s2_ff <= 1'b1;
			vld_s1_ff <= 1'b0;
			vld_s2_ff <= 1'b0;
			vld_s3_ff <= 1'b0;
		end else begin
			csn_s1_ff <= spi_csn_i;
			csn_s2_ff <= csn_s1_ff;
			vld_s1_ff <= rx_valid_ff;
			vld_s2_ff <= vld_s1_ff;
			vld_s3_ff <= vld_s2_ff;
		end
	end

	// Pins: unreset synchronisers, so the strap is settled at reset release
	always_ff @(posedge clk_sys_i) begin
		test_s1_ff  <= test_pin_i;
		test_s2_ff  <= test_s1_ff;
		strap_s1_ff <= strap_int_i;
		strap_s2_ff <= strap_s1_ff;
	end

	// The received word stays stable while valid is high, so it is read directly
	assign frame_acc = vld_s2_ff & ~vld_s3_ff;
	assign is_ro     = rx_frame.ms == MS_READ_ONLY;

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	logic            wd_trigger_ff, mode_req_ff, wr_strobe_ff, int_clear_ff;
	logic [MS_W-1:0] mode_code_ff;
	logic [CS_W-1:0] int_sel_ff;
	spi_frame_s      wr_frame_ff;

	// One pulse per accepted frame
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wd_trigger_ff <= 1'b0;
			mode_req_ff   <= 1'b0;
			mode_code_ff  <= MS_NORMAL;
			wr_strobe_ff  <= 1'b0;
			wr_frame_ff   <= '0;
			int_clear_ff  <= 1'b0;
			int_sel_ff    <= '0;
		end else begin
			wd_trigger_ff <= frame_acc;
			mode_req_ff   <= frame_acc & ~is_ro;
			wr_strobe_ff  <= frame_acc & ~is_ro & (rx_frame.cs != CS_DIAG);
			int_clear_ff  <= frame_acc & is_ro;
			// The link word is only known settled around the accept pulse
			if (frame_acc) begin
				mode_code_ff <= rx_frame.ms;
				wr_frame_ff  <= rx_frame;
			end
			if (frame_acc && is_ro) begin
				int_sel_ff <= rx_frame.cs;
			end
		end
	end

	// ---------------------------------------------------------------
	// Configuration, strap readout
	// ---------------------------------------------------------------
	reg_word_t  cfg_ff;
	logic       strap_taken_ff, strap_int_ff;
	logic [2:0] strap_ro_ff;
	logic       cfg_write;
	logic       dev_mode;

	assign cfg_write = frame_acc & ~is_ro & (rx_frame.cs == CS_CONFIG);
	assign dev_mode  = strap_ro_ff[STRAP_DEV_BIT];

	// Configuration register; the fallback bit lives in its own flop
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cfg_ff <= CFG_DEFAULT;
		end else if (cfg_write) begin
			cfg_ff <= rx_frame.data;
		end
	end

	// Strap caught once at the first edge after reset release
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			strap_taken_ff <= 1'b0;
			strap_int_ff   <= 1'b0;
		end else if (!strap_taken_ff) begin
			strap_taken_ff <= 1'b1;
			strap_int_ff   <= strap_s2_ff;
		end
	end

	// Bit 0 fail-safe vs restart, bit 1 failure count, bit 2 test pin
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			strap_ro_ff <= '0;
		end else begin
			strap_ro_ff <= {test_s2_ff, cfg_ff[CFG_WDLH_BIT], strap_int_ff};
		end
	end

	// ---------------------------------------------------------------
	// Fallback output and its cause
	// ---------------------------------------------------------------
	logic       fallback_on_ff, wd_pending_ff;
	logic [2:0] fb_cause_ff;
	logic       wd_real, wd_first;

	// Development mode masks watchdog failures entirely
	assign wd_real  = wd_fail_i & ~dev_mode;
	assign wd_first = wd_real & cfg_ff[CFG_WDLH_BIT] & ~wd_pending_ff;

	// Later statements win, so an event beats a same-cycle switch-off
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			fallback_on_ff <= 1'b0;
			fb_cause_ff    <= FB_NONE;
			wd_pending_ff  <= 1'b0;
		end else begin
			if (cfg_write) begin
				fallback_on_ff <= rx_frame.data[CFG_LH_BIT];
				if (!rx_frame.data[CFG_LH_BIT]) begin
					fb_cause_ff <= FB_NONE;
				end
			end
			if (wd_ok_i) begin
				wd_pending_ff <= 1'b0;
			end
			if (fb_event_i) begin
				fallback_on_ff <= 1'b1;
				fb_cause_ff    <= fb_code_i;
			end
			if (wd_first) begin
				wd_pending_ff <= 1'b1;
			end else if (wd_real) begin
				fallback_on_ff <= 1'b1;
				wd_pending_ff  <= 1'b0;
				fb_cause_ff    <= cfg_ff[CFG_WDLH_BIT] ? FB_WD_TWO : FB_WD_ONE;
			end
		end
	end

	// ---------------------------------------------------------------
	// Restart cause
	// ---------------------------------------------------------------
	logic [1:0] restart_ff;
	logic       ro_diag_read;

	assign ro_diag_read = frame_acc & is_ro & (rx_frame.cs == CS_DIAG);

	// Clears first, set events last so a new cause is never lost
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			restart_ff <= RC_NONE;
		end else begin
			if (ro_diag_read || return_clear_i) begin
				restart_ff <= RC_NONE;
			end
			if (fb_event_i || (wd_real && !wd_first)) begin
				restart_ff <= RC_NONE;
			end
			if (uv_restart_i) begin
				restart_ff <= RC_UNDERVOLT;
			end
			if (wd_first || cyclic_nack_i) begin
				restart_ff <= RC_WATCHDOG;
			end
			if (flash_cmd_i || ext_reset_i) begin
				restart_ff <= RC_COMMAND;
			end
		end
	end

	// ---------------------------------------------------------------
	// Response selection
	// ---------------------------------------------------------------
	logic [CS_W-1:0] next_sel_ff;
	logic            first_ff;
	logic [MS_W-1:0] first_ms_ff;

	// Normal-mode entry overrides any frame accepted in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			next_sel_ff <= CS_CONFIG;
			first_ff    <= 1'b0;
			first_ms_ff <= MS_INIT;
		end else begin
			if (frame_acc) begin
				first_ff <= 1'b0;
				if (!is_ro) begin
					next_sel_ff <= rx_frame.cs;
				end
			end
			if (normal_entry_i) begin
				first_ff    <= 1'b1;
				first_ms_ff <= prev_mode_i;
				unique case (prev_mode_i)
					MS_SLEEP:    next_sel_ff <= CS_WAKE;
					MS_FAILSAFE: next_sel_ff <= CS_DIAG;
					MS_RESTART:  next_sel_ff <= restart_by_uc_i ? CS_CONFIG : CS_DIAG;
					default:     next_sel_ff <= CS_CONFIG;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Register bank and snapshots for the link
	// ---------------------------------------------------------------
	reg_word_t  bank_w [REG_COUNT];
	reg_word_t  cfg_view;
	diag_s      diag_w;
	logic [MS_W-1:0] hdr_ms;

	assign diag_w   = '{restart_cause: restart_ff, fallback_cause: fb_cause_ff,
				strap_readout: strap_ro_ff};
	assign hdr_ms   = first_ff ? first_ms_ff : cur_mode_i;
	always_comb begin
		cfg_view             = cfg_ff;
		cfg_view[CFG_LH_BIT] = fallback_on_ff;
	end

	// Snapshots move only while deselected, so a frame sees frozen data;
	// chip select lead time covers the two-flop lag
	genvar gi;
	generate
		for (gi = 0; gi < REG_COUNT; gi++) begin : g_bank
			if (gi == int'(CS_CONFIG)) begin : g_cfg
				assign bank_w[gi] = cfg_view;
			end else if (gi == int'(CS_DIAG)) begin : g_diag
				assign bank_w[gi] = reg_word_t'(diag_w);
			end else begin : g_ext
				assign bank_w[gi] = ext_bank_i[gi];
			end
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					bank_snap_ff[gi] <= '0;
				end else if (csn_s2_ff) begin
					bank_snap_ff[gi] <= bank_w[gi];
				end
			end
		end
	endgenerate

	// Response frame for the next write command
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			tx_snap_ff <= '0;
		end else if (csn_s2_ff) begin
			tx_snap_ff <= {bank_w[next_sel_ff], next_sel_ff, hdr_ms};
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign wd_trigger_o        = wd_trigger_ff;
	assign mode_req_o          = mode_req_ff;
	assign mode_code_o         = mode_code_ff;
	assign wr_strobe_o         = wr_strobe_ff;
	assign wr_frame_o          = wr_frame_ff;
	assign int_clear_o         = int_clear_ff;
	assign int_sel_o           = int_sel_ff;
	assign fallback_on_o       = fallback_on_ff;
	assign wd_fallback_count_o = cfg_ff[CFG_WDLH_BIT];
	assign sw_dev_mode_o       = strap_ro_ff[STRAP_DEV_BIT];
	assign diag_o              = diag_w;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_ro_no_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		frame_acc && is_ro |=> !wr_strobe_o && !mode_req_o)
		else $error("read-only frame caused write or mode request");

	a_wd_trigger_pulse: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		$rose(vld_s2_ff) |=> wd_trigger_o ##1 !wd_trigger_o)
		else $error("watchdog trigger not a single pulse per frame");

	a_ro_clear_cause: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		ro_diag_read && !uv_restart_i && !wd_real && !cyclic_nack_i
		&& !flash_cmd_i && !ext_reset_i |=> diag_o.restart_cause == RC_NONE)
		else $error("restart cause survived read-only readout");

	a_return_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		return_clear_i && !uv_restart_i && !wd_real && !cyclic_nack_i
		&& !flash_cmd_i && !ext_reset_i |=> restart_ff == RC_NONE)
		else $error("restart cause survived mode return");

	a_lh_off_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		cfg_write && !rx_frame.data[CFG_LH_BIT] && !fb_event_i && !wd_real
		|=> fb_cause_ff == FB_NONE && !fallback_on_o)
		else $error("fallback cause not cleared on switch-off");

	a_sel_latch: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		frame_acc && !is_ro && !normal_entry_i |=> next_sel_ff == $past(rx_frame.cs))
		else $error("select of accepted command not latched");

	a_first_sleep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		normal_entry_i && prev_mode_i == MS_SLEEP
		|=> first_ff && next_sel_ff == CS_WAKE && first_ms_ff == MS_SLEEP)
		else $error("first frame after sleep misrouted");

	a_dev_ignore_wd: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		dev_mode && wd_fail_i && !fb_event_i && !frame_acc
		|=> $stable(fb_cause_ff) && $stable(fallback_on_ff))
		else $error("watchdog failure acted in development mode");

	a_wd_single: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		wd_real && !cfg_ff[CFG_WDLH_BIT] && !fb_event_i && !frame_acc
		|=> fallback_on_o && fb_cause_ff == FB_WD_ONE)
		else $error("single watchdog failure did not engage fallback");

endmodule // sbc_spi_diagnostic_readout

`default_nettype wire

/* tb/spi_host_model.sv */
// Host model: SPI master with clock idling high, frames shifted least significant bit first
`timescale 1ns/1ns
`default_nettype none
module spi_host_model
	import sbc_diag_pkg::*;
(
	// Link toward the device
	output logic      spi_clk_o,
	output logic      spi_csn_o,
	output logic      spi_sdi_o,
	input  wire logic spi_sdo_i
);
	// Clock stands high between frames; data rests low as its pull-down would leave it
	initial begin
		spi_clk_o = 1'b1;
		spi_csn_o = 1'b0;
		spi_sdi_o = 1'b0;
		#1;
		spi_csn_o = 1'b1; // A real rising select clears the link counters before use
	end
	// One whole frame; the lead time lets the device see the select before any edge
	task automatic xfer(input spi_frame_s tx, output logic [FRAME_BITS-1:0] rx);
		spi_csn_o = 1'b0;
		#100;
		for (int i = 0; i < FRAME_BITS; i++) begin
			spi_clk_o = 1'b0;
			spi_sdi_o = tx[i];
			#32;
			spi_clk_o = 1'b1;
			rx[i] = spi_sdo_i;
			#32;
		end
		spi_csn_o = 1'b1;
		spi_sdi_o = 1'b0;
		#200; // Gap well above six sys cycles
	endtask
endmodule // spi_host_model
`default_nettype wire

/* tb/sbc_spi_diagnostic_readout_tb.sv */
// Testbench: frame-level tests of the diagnostic readout
`timescale 1ns/1ns
`default_nettype none
module sbc_spi_diagnostic_readout_tb;
	import sbc_diag_pkg::*;
	logic clk_sys = 1'b0, reset_i = 1'b1, strap = 1'b1, tpin = 1'b0, uc = 1'b0;
	logic sck, csn, sdi, sdo;
	logic [8:0] evt = '0;
	logic [2:0] fbc = '0, pm = '0;
	logic [REG_COUNT-1:0][DATA_W-1:0] bank;
	logic [FRAME_BITS-1:0] rx;
	logic wtrig, mreq, wstb, iclr, fbon, wdcnt, dev, oen;
	logic [2:0] mcode;
	spi_frame_s wfr;
	logic [18:0] wlast = '0;
	logic [2:0] isel;
	diag_s diag;
	int failures = 0, check_count = 0, cyc = 0, n_trig = 0, n_mode = 0, t0, m0;
	int n_wstb = 0, n_iclr = 0, w0, i0;
	int pmv[5] = '{1, 3, 2, 2, 4};
	int ucv[5] = '{0, 0, 0, 1, 0};
	int csv[5] = '{0, 7, 7, 4, 4};
	int rcv[4] = '{1, 2, 3, 3};
	int rce[4] = '{0, 3, 4, 5};
	always #10 clk_sys = ~clk_sys;
	initial for (int i = 0; i < REG_COUNT; i++) bank[i] = 10'h2c0 | 10'(i);
	spi_host_model u_host (.spi_clk_o(sck), .spi_csn_o(csn), .spi_sdi_o(sdi), .spi_sdo_i(sdo));
	sbc_spi_diagnostic_readout u_dut (.clk_sys_i(clk_sys), .reset_i(reset_i), .spi_clk_i(sck),
		.spi_csn_i(csn), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_n_o(oen),
		.cur_mode_i(MS_NORMAL), .normal_entry_i(evt[8]), .prev_mode_i(pm),
		.restart_by_uc_i(uc), .return_clear_i(evt[7]), .uv_restart_i(evt[0]),
		.wd_fail_i(evt[1]), .wd_ok_i(evt[2]), .cyclic_nack_i(evt[3]), .flash_cmd_i(evt[4]),
		.ext_reset_i(evt[5]), .fb_event_i(evt[6]), .fb_code_i(fbc), .strap_int_i(strap),
		.test_pin_i(tpin), .ext_bank_i(bank), .wd_trigger_o(wtrig), .mode_req_o(mreq),
		.mode_code_o(mcode), .wr_strobe_o(wstb), .wr_frame_o(wfr), .int_clear_o(iclr),
		.int_sel_o(isel), .fallback_on_o(fbon), .wd_fallback_count_o(wdcnt),
		.sw_dev_mode_o(dev), .diag_o(diag));
	// Pulse counters and hang guard, sampled away from the launching edge
	always @(negedge clk_sys) begin
		n_trig += wtrig;
		n_mode += mreq;
		n_wstb += wstb;
		n_iclr += iclr;
		if (wstb) wlast = {wfr, mcode};
		cyc++;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One event input high for one cycle, then time for the flops to settle
	task automatic ev(input int b);
		@(negedge clk_sys) evt[b] = 1'b1;
		@(negedge clk_sys) evt[b] = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic frm(input logic [2:0] ms, input logic [2:0] cs, input logic [9:0] d);
		u_host.xfer('{data: d, cs: cs, ms: ms}, rx);
		@(negedge clk_sys);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk_sys);
		reset_i = 1'b0;
		repeat (6) @(negedge clk_sys);
		chk({diag, fbon, wdcnt, dev, oen}, {8'h03, 4'b0101});
		$display("test reset done");
		// Each restart cause, read back in the same frame, then cleared by that read
		for (int k = 0; k < 4; k++) begin
			ev(rce[k]);
			chk(diag.restart_cause, rcv[k]);
			t0 = n_trig;
			m0 = n_mode;
			w0 = n_wstb;
			i0 = n_iclr;
			frm(MS_READ_ONLY, CS_DIAG, '0);
			chk(rx[15:6], {4'h0, 2'(rcv[k]), 3'h0, 3'h3});
			chk(diag.restart_cause, RC_NONE);
			chk(n_trig - t0, 1);
			chk(n_mode - m0, 0);
			chk(n_wstb - w0, 0);
			chk(n_iclr - i0, 1);
			chk(isel, CS_DIAG);
		end
		ev(0);
		ev(7);
		chk(diag.restart_cause, RC_NONE);
		$display("test restart cause done");
		// Two failures with count bit set, then one with it clear
		ev(1);
		chk(diag.restart_cause, RC_WATCHDOG);
		ev(1);
		chk({fbon, diag.fallback_cause, diag.restart_cause}, 6'b1_011_00);
		frm(MS_NORMAL, CS_CONFIG, CFG_DEFAULT);
		chk({fbon, diag.fallback_cause}, 4'h0);
		frm(MS_NORMAL, CS_WAKE, '0);
		chk(rx, {CFG_DEFAULT, CS_CONFIG, MS_NORMAL});
		frm(MS_NORMAL, CS_CONFIG, 10'h015);
		chk({wdcnt, rx}, {1'b0, bank[0], CS_WAKE, MS_NORMAL});
		chk(wlast, {10'h015, CS_CONFIG, MS_NORMAL, MS_NORMAL});
		ev(1);
		chk({fbon, diag.fallback_cause}, {1'b1, FB_WD_ONE});
		for (int c = 1; c < 7; c++) begin
			fbc = 3'(c);
			ev(6);
			chk({fbon, diag.fallback_cause}, {1'b1, 3'(c)});
			frm(MS_NORMAL, CS_CONFIG, CFG_DEFAULT);
			chk({fbon, diag.fallback_cause}, 4'h0);
		end
		$display("test watchdog and fallback done");
		// First frame after entry; automatic diagnosis send keeps the cause
		ev(0);
		for (int k = 0; k < 5; k++) begin
			pm = 3'(pmv[k]);
			uc = ucv[k][0];
			ev(8);
			frm(MS_NORMAL, CS_WAKE, '0);
			chk(rx[5:0], {3'(csv[k]), 3'(pmv[k])});
		end
		chk(diag.restart_cause, RC_UNDERVOLT);
		t0 = n_trig;
		i0 = n_iclr;
		frm(MS_READ_ONLY, CS_WAKE, '0);
		chk(n_trig - t0, 1);
		chk(n_iclr - i0, 1);
		chk({isel, diag.restart_cause}, {CS_WAKE, RC_UNDERVOLT});
		$display("test first frame done");
		// A good trigger between failures withdraws the pending first failure
		ev(1);
		ev(2);
		ev(1);
		chk({fbon, diag.restart_cause}, {1'b0, RC_WATCHDOG});
		// Development mode ignores watchdog failures, even with one pending
		tpin = 1'b1;
		repeat (4) @(negedge clk_sys);
		ev(1);
		chk({dev, fbon, diag}, {2'b10, 2'b10, 3'b000, 3'b111});
		// A write to the diagnosis select asks for a mode but writes nothing
		m0 = n_mode;
		w0 = n_wstb;
		frm(MS_NORMAL, CS_DIAG, 10'h3ff);
		chk(n_wstb - w0, 0);
		chk(n_mode - m0, 1);
		chk(diag, {2'b10, 3'b000, 3'b111});
		$display("test development mode done");
		wrap_up();
	end
endmodule // sbc_spi_diagnostic_readout_tb
`default_nettype wire
